//--- rtl/sws_regs.vh
// register map, field positions, reset values and timing counts of the supervisor
`ifndef SWS_REGS_VH
`define SWS_REGS_VH

// register offsets
`define SWS_RCWC_ADDR      8'hB1
`define SWS_SDC_ADDR       8'hB3

// reset cause and watchdog control fields
`define SWS_RCWC_OVF_BIT   7
`define SWS_RCWC_POR_BIT   5
`define SWS_RCWC_LVR_BIT   4
`define SWS_RCWC_PIN_BIT   3
`define SWS_RCWC_PER_LSB   0
`define SWS_RCWC_POR_VAL   8'h20

// supply detector control fields
`define SWS_SDC_EN_BIT     7
`define SWS_SDC_STAT_BIT   6
`define SWS_SDC_MODE_BIT   5
`define SWS_SDC_IRQ_BIT    4
`define SWS_SDC_SEL_LSB    0
`define SWS_SDC_RST_VAL    8'h00

// overrange detection
`define SWS_PROG_LAST      16'h1FFF
`define SWS_ILL_OPCODE     8'hA5

// timing
`define SWS_CLK_MHZ        100
`define SWS_DEB_MIN_US     30
`define SWS_DEB_CYC        (`SWS_DEB_MIN_US * `SWS_CLK_MHZ)
`define SWS_WDT_TICK_US    1000
`define SWS_WDT_TICK_CYC   (`SWS_WDT_TICK_US * `SWS_CLK_MHZ)

`endif

//--- rtl/sws_supervisor.v
// supply detector, low-voltage reset, overrange check and watchdog with reset causes
`include "sws_regs.vh"

module sws_supervisor #(
    parameter integer WDT_TICK_CYC = `SWS_WDT_TICK_CYC
) (
    input  wire        clk,            // system clock, 100 MHz
    input  wire        nrst,           // power-on reset, active low
    input  wire [7:0]  reg_addr,       // register address
    input  wire [7:0]  reg_wdata,      // register write data
    input  wire        reg_we,         // write strobe
    input  wire        reg_re,         // read strobe
    output reg  [7:0]  reg_rdata,      // read data, cycle after strobe
    input  wire        vdd_below_det,  // comparator: supply below detector threshold
    input  wire        vdd_below_lvr,  // comparator: supply at or below lvr level
    output reg  [12:0] det_thr_mv,     // selected detector threshold in mV
    output reg         det_thr_valid,  // selected code is not reserved
    input  wire        lvr_option,     // factory option: low-voltage reset present
    input  wire        wdt_option,     // factory option: watchdog present
    input  wire        pd_wdt_option,  // factory option: watchdog runs in power-down
    input  wire        pd_mode,        // processor is in power-down
    input  wire        pin_reset,      // external pin reset event
    input  wire        fetch_valid,    // opcode fetch strobe
    input  wire [15:0] fetch_pc,       // program counter of the fetch
    input  wire [7:0]  fetch_opcode,   // fetched opcode
    output wire        det_irq,        // detector interrupt request
    output wire        wake_req,       // wake request out of power-down
    output wire        sys_reset,      // system reset request
    output wire        ovr_reset,      // overrange reset pulse
    output wire        wdt_expired     // watchdog overflow pulse
);

    // counts are worked out as integers, then cut to the counter widths on purpose
    localparam integer DEB_LAST_I  = `SWS_DEB_CYC - 1;
    localparam integer TICK_LAST_I = WDT_TICK_CYC - 1;
    localparam [11:0]  DEB_LAST    = DEB_LAST_I[11:0];
    localparam [16:0]  TICK_LAST   = TICK_LAST_I[16:0];

    // address decode used by write, read and watchdog restart
    function is_rcwc;
        input [7:0] a;
        begin
            is_rcwc = (a == `SWS_RCWC_ADDR);
        end
    endfunction

    function is_sdc;
        input [7:0] a;
        begin
            is_sdc = (a == `SWS_SDC_ADDR);
        end
    endfunction

    // detector threshold in mV; codes 1100 and 1101 are reserved and give zero
    function [12:0] det_mv;
        input [3:0] s;
        begin
            case (s)
                4'h0:    det_mv = 13'h0960;
                4'h1:    det_mv = 13'h09F6;
                4'h2:    det_mv = 13'h0A8C;
                4'h3:    det_mv = 13'h0B22;
                4'h4:    det_mv = 13'h0BB8;
                4'h5:    det_mv = 13'h0C4E;
                4'h6:    det_mv = 13'h0CE4;
                4'h7:    det_mv = 13'h0D7A;
                4'h8:    det_mv = 13'h0E10;
                4'h9:    det_mv = 13'h0EA6;
                4'hA:    det_mv = 13'h0F3C;
                4'hB:    det_mv = 13'h0FD2;
                4'hE:    det_mv = 13'h1068;
                4'hF:    det_mv = 13'h11C6;
                default: det_mv = 13'h0000;
            endcase
        end
    endfunction

    // minimum overflow period in 1 ms ticks
    function [12:0] wdt_ms;
        input [2:0] p;
        begin
            case (p)
                3'h0:    wdt_ms = 13'h1000;
                3'h1:    wdt_ms = 13'h0400;
                3'h2:    wdt_ms = 13'h0100;
                3'h3:    wdt_ms = 13'h0080;
                3'h4:    wdt_ms = 13'h0040;
                3'h5:    wdt_ms = 13'h0010;
                3'h6:    wdt_ms = 13'h0004;
                default: wdt_ms = 13'h0001;
            endcase
        end
    endfunction

    // software-visible fields and flags, with internal edge history, pulses and watchdog counters
    reg        det_en_reg;
    reg        det_mode_reg;
    reg [3:0]  det_sel_reg;
    reg        det_irq_reg;
    reg        det_stat_d_reg;
    reg [2:0]  wdt_per_reg;
    reg        flag_ovf_reg;
    reg        flag_por_reg;
    reg        flag_lvr_reg;
    reg        flag_pin_reg;
    reg        lvr_d_reg;
    reg        ovr_reg;
    reg        wdt_ovf_reg;
    reg [16:0] pre_reg;
    reg [12:0] wdt_cnt_reg;

    wire       wr_rcwc = reg_we & is_rcwc(reg_addr);
    wire       wr_sdc  = reg_we & is_sdc(reg_addr);

    // raw conditions ahead of the debouncers
    wire [1:0] deb_raw;
    wire [1:0] deb_ok;
    wire       det_cond = det_mode_reg ? ~vdd_below_det : vdd_below_det;
    assign deb_raw[0] = det_en_reg & det_cond;
    assign deb_raw[1] = lvr_option & vdd_below_lvr;

    // persistence filters; a condition that drops restarts its count at once
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_deb
            reg [11:0] cnt_reg;
            reg        ok_reg;
            always @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    cnt_reg <= 12'h000;
                    ok_reg  <= 1'b0;
                end else if (!deb_raw[g]) begin
                    cnt_reg <= 12'h000;
                    ok_reg  <= 1'b0;
                end else if (cnt_reg == DEB_LAST) begin
                    ok_reg  <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 12'h001;
                end
            end
            assign deb_ok[g] = ok_reg;
        end
    endgenerate

    wire det_stat = deb_ok[0];
    wire det_rise = det_stat & ~det_stat_d_reg;
    wire lvr_hold = deb_ok[1];
    wire lvr_rise = lvr_hold & ~lvr_d_reg;

    // overrange: address past the last program byte or the unused opcode
    wire ovr_hit = fetch_valid & ((fetch_pc > `SWS_PROG_LAST) |
                                  (fetch_opcode == `SWS_ILL_OPCODE));

    // every reset cause other than power-on; control registers return to reset values, the cause flags keep theirs
    wire soft_rst = lvr_hold | pin_reset | ovr_reg | wdt_ovf_reg;

    // watchdog clock gating; stopped in power-down unless the option keeps it
    wire wdt_run  = wdt_option & ~(pd_mode & ~pd_wdt_option);
    wire wdt_kick = ((reg_we | reg_re) & is_rcwc(reg_addr)) | soft_rst;
    wire wdt_tick = wdt_run & (pre_reg == TICK_LAST);

    // 1 ms prescaler stands in for the separate rc oscillator
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre_reg <= 17'h00000;
        end else if (wdt_kick | wdt_tick) begin
            pre_reg <= 17'h00000;
        end else if (wdt_run) begin
            pre_reg <= pre_reg + 17'h00001;
        end
    end

    // down counter; one extra tick at zero keeps the period a minimum
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wdt_cnt_reg <= 13'h1000;
            wdt_ovf_reg <= 1'b0;
        end else begin
            wdt_ovf_reg <= 1'b0;
            if (wdt_kick) begin
                wdt_cnt_reg <= wdt_ms(soft_rst ? 3'h0 : wdt_per_reg);
            end else if (wdt_tick) begin
                if (wdt_cnt_reg == 13'h0000) begin
                    wdt_ovf_reg <= 1'b1;
                    wdt_cnt_reg <= wdt_ms(3'h0);
                end else begin
                    wdt_cnt_reg <= wdt_cnt_reg - 13'h0001;
                end
            end
        end
    end

    // overrange pulse and edge history
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ovr_reg        <= 1'b0;
            lvr_d_reg      <= 1'b0;
            det_stat_d_reg <= 1'b0;
        end else begin
            ovr_reg        <= ovr_hit;
            lvr_d_reg      <= lvr_hold;
            det_stat_d_reg <= det_stat;
        end
    end

    // detector control; all reset types return it to zero
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            det_en_reg   <= 1'b0;
            det_mode_reg <= 1'b0;
            det_sel_reg  <= 4'h0;
        end else if (soft_rst) begin
            det_en_reg   <= 1'b0;
            det_mode_reg <= 1'b0;
            det_sel_reg  <= 4'h0;
        end else if (wr_sdc) begin
            det_en_reg   <= reg_wdata[`SWS_SDC_EN_BIT];
            det_mode_reg <= reg_wdata[`SWS_SDC_MODE_BIT];
            det_sel_reg  <= reg_wdata[`SWS_SDC_SEL_LSB +: 4];
        end
    end

    // interrupt flag: a new event beats a same-cycle clear, writing 1 does nothing
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            det_irq_reg <= 1'b0;
        end else if (det_rise) begin
            det_irq_reg <= 1'b1;
        end else if (soft_rst) begin
            det_irq_reg <= 1'b0;
        end else if (wr_sdc && !reg_wdata[`SWS_SDC_IRQ_BIT]) begin
            det_irq_reg <= 1'b0;
        end
    end

    // period field; any reset type brings back the longest period
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wdt_per_reg <= 3'h0;
        end else if (soft_rst) begin
            wdt_per_reg <= 3'h0;
        end else if (wr_rcwc) begin
            wdt_per_reg <= reg_wdata[`SWS_RCWC_PER_LSB +: 3];
        end
    end

    // reset cause flags; set wins over a software clear in the same cycle
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_ovf_reg <= 1'b0;
            flag_por_reg <= 1'b1;
            flag_lvr_reg <= 1'b0;
            flag_pin_reg <= 1'b0;
        end else begin
            if (ovr_reg | wdt_ovf_reg)
                flag_ovf_reg <= 1'b1;
            else if (wr_rcwc && !reg_wdata[`SWS_RCWC_OVF_BIT])
                flag_ovf_reg <= 1'b0;
            if (wr_rcwc && !reg_wdata[`SWS_RCWC_POR_BIT])
                flag_por_reg <= 1'b0;
            if (lvr_rise)
                flag_lvr_reg <= 1'b1;
            else if (wr_rcwc && !reg_wdata[`SWS_RCWC_LVR_BIT])
                flag_lvr_reg <= 1'b0;
            if (pin_reset)
                flag_pin_reg <= 1'b1;
            else if (wr_rcwc && !reg_wdata[`SWS_RCWC_PIN_BIT])
                flag_pin_reg <= 1'b0;
        end
    end

    // threshold decode registered so the analog side sees a stable code
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            det_thr_mv    <= 13'h0000;
            det_thr_valid <= 1'b0;
        end else begin
            det_thr_mv    <= det_mv(det_sel_reg);
            det_thr_valid <= (det_mv(det_sel_reg) != 13'h0000);
        end
    end

    // read data, valid only in the cycle after the strobe; unmapped reads zero
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_re && is_rcwc(reg_addr)) begin
            reg_rdata <= {flag_ovf_reg, 1'b0, flag_por_reg, flag_lvr_reg,
                          flag_pin_reg, wdt_per_reg};
        end else if (reg_re && is_sdc(reg_addr)) begin
            reg_rdata <= {det_en_reg, det_stat, det_mode_reg, det_irq_reg,
                          det_sel_reg};
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // outputs; low-voltage reset holds as long as the supply stays low
    assign det_irq     = det_irq_reg;
    assign wake_req    = det_irq_reg & pd_mode;
    assign sys_reset   = lvr_hold | ovr_reg | wdt_ovf_reg;
    assign ovr_reset   = ovr_reg;
    assign wdt_expired = wdt_ovf_reg;

endmodule // sws_supervisor

//--- bench/sws_supervisor_properties.sv
// port-level assertions for the supervisor, bound into the design
`include "sws_regs.vh"
module sws_supervisor_chk #(
    parameter integer WDT_TICK_CYC = 10
) (
    input wire logic        clk,           // clock
    input wire logic        nrst,          // reset
    input wire logic [7:0]  reg_addr,      // bus
    input wire logic [7:0]  reg_wdata,     // bus
    input wire logic        reg_we,        // bus
    input wire logic        reg_re,        // bus
    input wire logic [7:0]  reg_rdata,     // bus
    input wire logic        vdd_below_det, // comparator
    input wire logic        vdd_below_lvr, // comparator
    input wire logic [12:0] det_thr_mv,    // threshold
    input wire logic        det_thr_valid, // threshold ok
    input wire logic        lvr_option,    // option
    input wire logic        wdt_option,    // option
    input wire logic        pd_wdt_option, // option
    input wire logic        pd_mode,       // power-down
    input wire logic        pin_reset,     // pin reset
    input wire logic        fetch_valid,   // fetch
    input wire logic [15:0] fetch_pc,      // fetch
    input wire logic [7:0]  fetch_opcode,  // fetch
    input wire logic        det_irq,       // irq
    input wire logic        wake_req,      // wake
    input wire logic        sys_reset,     // reset out
    input wire logic        ovr_reset,     // overrange
    input wire logic        wdt_expired    // overflow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [12:0] lvr_cnt;
    logic        bad_q;
    logic        halt_q;
    wire         bad_now  = fetch_valid && (fetch_pc > `SWS_PROG_LAST
                            || fetch_opcode == `SWS_ILL_OPCODE);
    wire         halt_now = !wdt_option || (pd_mode && !pd_wdt_option);
    // saturating, so a long brown-out never wraps back to a short one
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lvr_cnt <= 13'h0000;
            bad_q   <= 1'b0;
            halt_q  <= 1'b1;
        end else begin
            bad_q  <= bad_now;
            halt_q <= halt_now;
            if (!(lvr_option && vdd_below_lvr))
                lvr_cnt <= 13'h0000;
            else if (lvr_cnt != 13'h1FFF)
                lvr_cnt <= lvr_cnt + 13'h0001;
        end
    end
    chk_lvr_long_low: assert property (lvr_cnt >= 13'h0BBD |-> sys_reset)
        else $error("reset missing after long low supply");
    chk_lvr_short_dip: assert property (sys_reset && !ovr_reset && !wdt_expired
        |-> $past(lvr_cnt) >= 13'h0BB0)
        else $error("reset without filtered low supply");
    chk_ovr_cause: assert property (ovr_reset == bad_q)
        else $error("overrange pulse not tied to bad fetch");
    chk_ovr_to_sys: assert property (ovr_reset |-> sys_reset)
        else $error("overrange pulse without system reset");
    chk_wdt_to_sys: assert property (wdt_expired |-> sys_reset)
        else $error("overflow without system reset");
    chk_wdt_halted: assert property (halt_q && halt_now |-> !wdt_expired)
        else $error("overflow while watchdog halted");
    chk_wdt_reload: assert property (wdt_expired |=> !wdt_expired [*8])
        else $error("overflow repeats right after reset");
    chk_wake_follow: assert property (wake_req == (det_irq && pd_mode))
        else $error("wake request not from detector interrupt");
    chk_thr_span: assert property (det_thr_valid ? (det_thr_mv >= 13'h0960
        && det_thr_mv <= 13'h11C6) : det_thr_mv == 13'h0000)
        else $error("threshold out of span");
    cover property (sys_reset && lvr_cnt != 13'h0000);
    cover property (ovr_reset);
    cover property (wdt_expired);
    cover property (wake_req);
endmodule // sws_supervisor_chk

bind sws_supervisor sws_supervisor_chk #(.WDT_TICK_CYC(WDT_TICK_CYC)) u_chk (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .vdd_below_det(vdd_below_det), .vdd_below_lvr(vdd_below_lvr),
    .det_thr_mv(det_thr_mv), .det_thr_valid(det_thr_valid), .lvr_option(lvr_option),
    .wdt_option(wdt_option), .pd_wdt_option(pd_wdt_option), .pd_mode(pd_mode),
    .pin_reset(pin_reset), .fetch_valid(fetch_valid), .fetch_pc(fetch_pc),
    .fetch_opcode(fetch_opcode), .det_irq(det_irq), .wake_req(wake_req),
    .sys_reset(sys_reset), .ovr_reset(ovr_reset), .wdt_expired(wdt_expired)
);

//--- bench/sws_supervisor_bench.sv
// randomised self-checking bench of the supply and watchdog supervisor
`include "sws_regs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module sws_supervisor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, nrst = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
    logic        vdd_below_det = 1'b0, vdd_below_lvr = 1'b0, lvr_option = 1'b0;
    logic        wdt_option = 1'b0, pd_wdt_option = 1'b0, pd_mode = 1'b0;
    logic        pin_reset = 1'b0, fetch_valid = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, fetch_opcode = 8'h00, m;
    logic [15:0] fetch_pc = 16'h0000;
    wire  [7:0]  reg_rdata;
    wire  [12:0] det_thr_mv;
    wire         det_thr_valid, det_irq, wake_req, sys_reset, ovr_reset, wdt_expired;
    integer      seed = 79632, miscompares = 0, compares = 0, hits = 0, base = 0, i, k;

    sws_supervisor #(.WDT_TICK_CYC(10)) dut (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .vdd_below_det(vdd_below_det), .vdd_below_lvr(vdd_below_lvr),
        .det_thr_mv(det_thr_mv), .det_thr_valid(det_thr_valid), .lvr_option(lvr_option),
        .wdt_option(wdt_option), .pd_wdt_option(pd_wdt_option), .pd_mode(pd_mode),
        .pin_reset(pin_reset), .fetch_valid(fetch_valid), .fetch_pc(fetch_pc),
        .fetch_opcode(fetch_opcode), .det_irq(det_irq), .wake_req(wake_req),
        .sys_reset(sys_reset), .ovr_reset(ovr_reset), .wdt_expired(wdt_expired)
    );

    // 100 MHz clock; overflow pulses are counted for the watchdog checks
    always #5 clk = ~clk;
    always @(posedge clk) if (wdt_expired === 1'b1) hits <= hits + 1;

    // expected threshold in mV; the two reserved codes read as zero
    function automatic [12:0] thr(input [3:0] c);
        if (c == 4'hC || c == 4'hD) return 13'h0000;
        if (c == 4'hE) return 13'h1068;
        if (c == 4'hF) return 13'h11C6;
        return 13'h0960 + 13'h0096 * c;
    endfunction
    task automatic cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input [7:0] a, input [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input [7:0] a, input [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 `CHK(reg_rdata, e)
        // return on an edge so later input changes stay edge-aligned
        @(posedge clk);
    endtask
    task automatic fetch(input [15:0] pc, input [7:0] op);
        @(posedge clk);
        fetch_valid <= 1'b1;
        fetch_pc <= pc;
        fetch_opcode <= op;
        @(posedge clk);
        fetch_valid <= 1'b0;
        #1;
    endtask
    task automatic complete_run;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // bounded wait for an overflow; running out ends the run as a failure
    task automatic wait_hit;
        for (int n = 0; n < 200 && hits == base; n++) @(posedge clk);
        if (hits == base) begin
            miscompares++;
            complete_run;
        end
    endtask

    initial begin
        cyc(16);
        nrst <= 1'b1;
        rd(8'hB1, 8'h20);
        rd(8'hB3, 8'h00);
        rd(8'h5A, 8'h00);
        wr(8'hB1, 8'hFF);
        rd(8'hB1, 8'h27);
        for (i = 0; i < 8; i++) begin
            wr(8'hB1, i[7:0]);
            rd(8'hB1, i[7:0]);
        end
        for (i = 0; i < 16; i++) begin
            wr(8'hB3, i[7:0]);
            cyc(2);
            #1 `CHK(det_thr_mv, thr(i[3:0]))
            `CHK(det_thr_valid, i < 12 || i > 13)
        end
        cyc(1);
        // both polarities, random threshold code
        for (k = 0; k < 2; k++) begin
            m = 8'h80 | (k << 5) | ($random(seed) & 8'h0F);
            vdd_below_det <= (k == 0);
            wr(8'hB3, m);
            cyc(2900);
            rd(8'hB3, m);
            cyc(150);
            rd(8'hB3, m | 8'h50);
            pd_mode <= 1'b1;
            cyc(1);
            #1 `CHK(wake_req, 1'b1)
            `CHK(det_irq, 1'b1)
            cyc(1);
            pd_mode <= 1'b0;
            vdd_below_det <= (k != 0);
            cyc(2);
            rd(8'hB3, m | 8'h10);
            wr(8'hB3, m | 8'h10);
            rd(8'hB3, m | 8'h10);
            wr(8'hB3, m);
            rd(8'hB3, m);
        end
        vdd_below_det <= 1'b1;
        wr(8'hB3, 8'h05);
        cyc(3100);
        rd(8'hB3, 8'h05);
        fetch(16'h2000, 8'h00);
        `CHK({ovr_reset, sys_reset}, 2'b11)
        rd(8'hB1, 8'h80);
        rd(8'hB3, 8'h00);
        wr(8'hB1, 8'h00);
        fetch(16'h0100, `SWS_ILL_OPCODE);
        `CHK(ovr_reset, 1'b1)
        rd(8'hB1, 8'h80);
        wr(8'hB1, 8'h00);
        for (i = 0; i < 40; i++) begin
            m = $random(seed);
            fetch($random(seed) & 16'h1FFF, (m == 8'hA5) ? 8'h00 : m);
            `CHK(ovr_reset, 1'b0)
        end
        wr(8'hB1, 8'h03);
        pin_reset <= 1'b1;
        cyc(1);
        pin_reset <= 1'b0;
        rd(8'hB1, 8'h08);
        wr(8'hB1, 8'h00);
        vdd_below_lvr <= 1'b1;
        cyc(3100);
        #1 `CHK(sys_reset, 1'b0)
        cyc(1);
        lvr_option <= 1'b1;
        cyc(2000);
        #1 `CHK(sys_reset, 1'b0)
        cyc(1);
        vdd_below_lvr <= 1'b0;
        cyc(2);
        vdd_below_lvr <= 1'b1;
        cyc(3100);
        #1 `CHK(sys_reset, 1'b1)
        cyc(1);
        vdd_below_lvr <= 1'b0;
        cyc(3);
        #1 `CHK(sys_reset, 1'b0)
        rd(8'hB1, 8'h10);
        // ones in the flag bits keep the low-voltage flag for the reads below
        wr(8'hB1, 8'h17);
        wdt_option <= 1'b1;
        base = hits;
        // kicks every few cycles, well inside the shortest period
        for (i = 0; i < 10; i++) begin
            rd(8'hB1, 8'h17);
            cyc(4);
        end
        `CHK(hits - base, 0)
        wait_hit;
        `CHK(hits - base, 1)
        rd(8'hB1, 8'h90);
        // a write restarts with the old period, so a read arms the shortest one
        wr(8'hB1, 8'h97);
        rd(8'hB1, 8'h97);
        pd_mode <= 1'b1;
        base = hits;
        cyc(100);
        `CHK(hits - base, 0)
        pd_wdt_option <= 1'b1;
        wait_hit;
        `CHK(hits - base, 1)
        wdt_option <= 1'b0;
        pd_mode <= 1'b0;
        complete_run;
    end
endmodule // sws_supervisor_bench
